/* File: tb/host_model.sv */
// Purpose: host serial controller with a downstream chained device
// Assumes: link clock idles low outside frames, 80 ns period
// Notes: each bit is read just before the next rising link edge
// host setup and chain sizing, no pins here
`timescale 1ns/1ns
module host_model
(
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_chain,
	input  wire logic i_dout
);
	logic [511:0] got; // captured bits, first at index 0
	initial
	begin
		o_sclk = 0;
		o_cs_n = 1;
		o_chain = 0;
	end
	// one frame; downstream word leads the chain line, then ground
	task automatic frame(input int n, input logic chained, input logic [23:0] cw);
		#2; // keep pin changes clear of the system clock edge when the frame is called on one
		o_cs_n = 0;
		#80;
		for (int k = 0; k < n; k++)
		begin
			o_sclk = 1;
			o_chain = chained && k < 24 && cw[23-k];
			#40 o_sclk = 0;
			#40 got[k] = i_dout;
		end
		#80 o_cs_n = 1;
		o_chain = 0;
		#160;
	endtask
endmodule

/* File: tb/tb_multi_device_serial_chain.sv */
// Purpose: self-checking bench for the chained serial output block
// Assumes: host_model drives the link, bench drives the rest
// Notes: latency is checked to the exact cycle, bench drives start on the edge
`timescale 1ns/1ns
module tb_multi_device_serial_chain;
	import serial_chain_pkg::*;
	localparam int LAT = 16; // start to done cycles
	logic         i_ref_clk = 0, i_rst_n = 0, i_start = 0, i_smp_valid = 0, i_clock_source_select_pin = 0;
	logic [23:0]  down_w; // word sent by the downstream device
	logic [7:0]   i_cfg1 = 0, i_cfg4 = 0, i_lead_off_control_register_p = 0, i_lead_off_control_register_n = 0;
	logic [191:0] i_smp_data = '0; // eight samples, ch0 on top
	wire          sclk, cs_n, chain, ready, dout, oe_n, conversion_done_indicator_n, cen, comp;
	int           miscompares = 0, checked = 0;
	logic [31:0]  seed = 32'd79697; // xorshift state
	logic [191:0] d;
	int           cnt;
	// a released line shows the inverse, so a float during a frame is caught
	wire          dout_line = oe_n ? ~dout : dout;
	always #4 i_ref_clk = ~i_ref_clk;
	serial_chain #(.LATENCY_CYC(LAT)) i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_sclk(sclk), .i_cs_n(cs_n), .i_chain_in(chain), .i_start(i_start),
		.i_clock_source_select_pin(i_clock_source_select_pin), .i_cfg1(i_cfg1), .i_cfg4(i_cfg4), .i_lead_off_control_register_p(i_lead_off_control_register_p),
		.i_lead_off_control_register_n(i_lead_off_control_register_n), .i_smp_valid(i_smp_valid), .i_smp_data(i_smp_data),
		.o_smp_ready(ready), .o_dout(dout), .o_dout_oe_n(oe_n), .o_conversion_done_indicator_n(conversion_done_indicator_n),
		.o_clk_out_en(cen), .o_comp_en(comp));
	host_model i_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_chain(chain), .i_dout(dout_line));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// word w of the captured frame, msb first on the wire
	function automatic logic [23:0] word(input int w);
		logic [23:0] r;
		for (int i = 0; i < 24; i++)
			r[23-i] = i_host.got[24*w+i];
		return r;
	endfunction
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// offer a random sample, held until ready is seen at a rising edge
	task automatic push();
		d = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
		@(posedge i_ref_clk);
		i_smp_data <= d;
		i_smp_valid <= 1;
		for (int t = 0; t < 50 && ready !== 1'b1; t++)
			@(negedge i_ref_clk);
		check(24'(ready), 24'h1);
		@(posedge i_ref_clk);
		i_smp_valid <= 0;
		repeat (8) @(posedge i_ref_clk);
	endtask
	// read one frame and compare status plus own samples
	task automatic own_frame(input logic chained, input logic [23:0] cw);
		i_host.frame(240, chained, cw);
		check(word(9), chained ? cw : 24'h0);
		check(word(0), STATUS_HEAD | {8'h00, i_lead_off_control_register_p, i_lead_off_control_register_n});
		for (int w = 0; w < CHANNELS; w++)
			check(word(w+1), d[191-24*w -: 24]);
		check(24'(oe_n), 24'h1);
	endtask
	initial
	begin
		repeat (5) @(posedge i_ref_clk);
		i_rst_n <= 1;
		check({dout, oe_n, conversion_done_indicator_n}, 3'b011);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge i_ref_clk);
			i_cfg4 <= 8'(rnd()) ^ 8'(i << CFG4_COMP_BIT);
			i_clock_source_select_pin <= 1'(i >> 1);
			repeat (6) @(posedge i_ref_clk);
			check(24'(comp), 24'(i_cfg4[CFG4_COMP_BIT]));
			check(24'(cen), 24'(i_clock_source_select_pin));
		end
		i_cfg4 <= 8'h02;
		repeat (6) @(posedge i_ref_clk);
		check(24'(comp), 24'h1);
		i_lead_off_control_register_p <= 8'(rnd());
		i_lead_off_control_register_n <= 8'hff; // corner: every negative electrode off
		push();
		own_frame(0, 24'h0);
		own_frame(0, 24'h0); // unchained re-read returns the same frame
		@(posedge i_ref_clk);
		i_cfg1 <= 8'(1 << CFG1_CHAIN_BIT); // chain enable
		push();
		down_w = 24'(rnd());
		own_frame(1, down_w);
		i_host.frame(240, 0, 24'h0); // chained re-read finds nothing left
		check(word(0), 24'h0);
		check(word(1), 24'h0);
		@(posedge i_ref_clk);
		i_start <= 1;
		cnt = 0;
		while (conversion_done_indicator_n !== 1'b0 && cnt < 100)
		begin
			@(negedge i_ref_clk);
			cnt++;
		end
		// two sync flops, the edge detector, then the counter, seen at a negedge
		check(24'(cnt), 24'(LAT+4));
		i_start <= 0;
		i_host.frame(8, 0, 24'h0);
		check(24'(conversion_done_indicator_n), 24'h1);
		conclude();
	end
	initial
	begin
		#500000;
		miscompares++;
		conclude();
	end
endmodule

/* File: verilog/serial_chain.sv */
// Purpose: serial output of one converter in cascade or chained operation
// Assumes: serial clock and chip select arrive from outside, sampled at 125 MHz
// Notes: serial clock must be well below an eighth of the system clock
`timescale 1ns/1ns
module serial_chain
	import serial_chain_pkg::*;
#(
	parameter int LATENCY_CYC = 16   // start to done cycles, fixed per data rate
)
(
	input  wire logic                         i_ref_clk,
	input  wire logic                         i_rst_n,
	input  wire logic                         i_sclk,
	input  wire logic                         i_cs_n,
	input  wire logic                         i_chain_in,
	input  wire logic                         i_start,
	input  wire logic                         i_clock_source_select_pin,
	input  wire logic [7:0]                   i_cfg1,
	input  wire logic [7:0]                   i_cfg4,
	input  wire logic [7:0]                   i_lead_off_control_register_p,
	input  wire logic [7:0]                   i_lead_off_control_register_n,
	input  wire logic                         i_smp_valid,
	input  wire logic [WORD_BITS*CHANNELS-1:0] i_smp_data,
	output logic                              o_smp_ready,
	output logic                              o_dout,
	output logic                              o_dout_oe_n,
	output logic                              o_conversion_done_indicator_n,
	output logic                              o_clk_out_en,
	output logic                              o_comp_en
);
	localparam int FRAME_BITS = WORD_BITS*(CHANNELS+1); // own frame length
	localparam int FW = WORD_BITS*CHANNELS;

	// two-flop synchronisers for pins
	logic [1:0] sclk_s_r, cs_s_r, din_s_r, start_s_r;
	logic       sclk_d_r, start_d_r;
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sclk_s_r  <= 2'h0;
			cs_s_r    <= 2'h3;
			din_s_r   <= 2'h0;
			start_s_r <= 2'h0;
			sclk_d_r  <= 1'b0;
			start_d_r <= 1'b0;
		end
		else
		begin
			sclk_s_r  <= {sclk_s_r[0], i_sclk};
			cs_s_r    <= {cs_s_r[0], i_cs_n};
			din_s_r   <= {din_s_r[0], i_chain_in};
			start_s_r <= {start_s_r[0], i_start};
			sclk_d_r  <= sclk_s_r[1];
			start_d_r <= start_s_r[1];
		end
	end
	wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
	wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;
	wire cs_act    = ~cs_s_r[1];
	wire start_rise = start_s_r[1] & ~start_d_r;
	wire chain_en  = i_cfg1[CFG1_CHAIN_BIT];

	// static config outputs
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_comp_en    <= 1'b0;
			o_clk_out_en <= 1'b0;
		end
		else
		begin
			o_comp_en    <= i_cfg4[CFG4_COMP_BIT];
			o_clk_out_en <= i_clock_source_select_pin;
		end
	end

	// two-entry sample buffer so a word arriving mid-frame waits for the frame to end
	logic [FW-1:0] buf_mem [BUF_DEPTH];
	logic          wr_ptr_r, rd_ptr_r;
	logic [1:0]    count_r;
	logic          pop;
	// a word moves only when valid meets ready; ready falls with the push, but an offer still held after the pop is taken again
	wire           push = i_smp_valid && o_smp_ready && (count_r != 2'h2);
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_ptr_r    <= 1'b0;
			rd_ptr_r    <= 1'b0;
			count_r     <= 2'd0;
			o_smp_ready <= 1'b0;
		end
		else
		begin
			if (push)
			begin
				buf_mem[wr_ptr_r] <= i_smp_data;
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			count_r <= count_r + {1'b0, push} - {1'b0, pop};
			// ready stays registered, so only advertise a sure free slot
			o_smp_ready <= (count_r + {1'b0, push} - {1'b0, pop}) == 2'd0;
		end
	end

	// frame shifter: own frame first, chain bits fill in behind it
	logic [FRAME_BITS-1:0] shift_r;     // bits still to leave on the output
	logic [FRAME_BITS-1:0] frame_r;     // copy of the own frame for repeated readback
	logic [CNT_W+1:0]      bit_cnt_r;   // rising link edges seen in this frame
	logic                  chain_bit_r; // last bit taken from the chain input
	logic                  frame_act_r; // chip select was seen low
	wire [WORD_BITS-1:0] status_w = {STATUS_HEAD[23:16], i_lead_off_control_register_p, i_lead_off_control_register_n};
	assign pop = (count_r != 2'd0) && !frame_act_r && !cs_act;
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			shift_r     <= '0;
			frame_r     <= '0;
			bit_cnt_r   <= '0;
			chain_bit_r <= 1'b0;
			frame_act_r <= 1'b0;
			o_dout      <= 1'b0;
		end
		else if (pop)
		begin
			shift_r <= {status_w, buf_mem[rd_ptr_r]};
			frame_r <= {status_w, buf_mem[rd_ptr_r]};
		end
		else if (cs_act)
		begin
			frame_act_r <= 1'b1;
			if (sclk_fall)
			begin
				// a bit entering behind the own frame leaves right after it
				chain_bit_r <= din_s_r[1];
				shift_r     <= {shift_r[FRAME_BITS-2:0], din_s_r[1] & chain_en};
			end
			if (sclk_rise)
			begin
				bit_cnt_r <= bit_cnt_r + 1'b1;
				if (chain_en || bit_cnt_r < FRAME_BITS[CNT_W+1:0])
					o_dout <= shift_r[FRAME_BITS-1];
				else
					o_dout <= 1'b0;
			end
		end
		else
		begin
			// chained: the shifter now holds other devices' bits, so no re-read
			if (frame_act_r)
				shift_r <= chain_en ? '0 : frame_r;
			frame_act_r <= 1'b0;
			bit_cnt_r   <= '0;
		end
	end

	// output enable follows chip select
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_dout_oe_n <= 1'b1;
		else
			o_dout_oe_n <= ~cs_act;
	end

	// fixed latency start to done
	logic [15:0] lat_r;
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			lat_r    <= '0;
			o_conversion_done_indicator_n <= 1'b1;
		end
		else if (start_rise)
		begin
			lat_r    <= 16'(LATENCY_CYC);
			o_conversion_done_indicator_n <= 1'b1;
		end
		else if (lat_r != 16'h0)
		begin
			lat_r <= lat_r - 16'h1;
			if (lat_r == 16'h1)
				o_conversion_done_indicator_n <= 1'b0;
		end
		else if (cs_act)
			o_conversion_done_indicator_n <= 1'b1;
	end

	oe_follow_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		!cs_act |=> o_dout_oe_n) else $error("output not floated");
	comp_en_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		1 |=> o_comp_en == $past(i_cfg4[CFG4_COMP_BIT])) else $error("comparator bit");
	latency_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		start_rise |=> o_conversion_done_indicator_n ##LATENCY_CYC !o_conversion_done_indicator_n) else $error("done latency wrong");
	dout_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		!sclk_rise |=> $stable(o_dout)) else $error("output moved off edge");
	chain_fwd_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		cs_act && sclk_rise && !chain_en && bit_cnt_r >= FRAME_BITS[CNT_W+1:0]
		|=> !o_dout) else $error("forwarding while unchained");
	buf_full_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		count_r != 2'd0 |-> !o_smp_ready) else $error("ready while holding");
	clk_out_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		1 |=> o_clk_out_en == $past(i_clock_source_select_pin)) else $error("clock out enable");
	chain_cap_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		cs_act && sclk_fall && !pop |=> chain_bit_r == $past(din_s_r[1]))
		else $error("chain bit not captured");
	frame_c: cover property (@(posedge i_ref_clk) cs_act && sclk_rise && bit_cnt_r == 10'd215);
	chain_c: cover property (@(posedge i_ref_clk) chain_en && cs_act && bit_cnt_r == 10'd230);
	done_c: cover property (@(posedge i_ref_clk) $fell(o_conversion_done_indicator_n));
endmodule

/* File: verilog/serial_chain_pkg.sv */
// Purpose: constants for the chained serial output block
// Assumes: 24-bit status and 24-bit samples, msb first
// Notes: shared by the block and its bench
package serial_chain_pkg;
	localparam int          WORD_BITS      = 24;       // bits per status word or sample
	localparam int          CHANNELS       = 8;        // samples per own frame
	localparam int          CNT_W          = 8;        // bit counter width less two
	localparam int          WORD_CNT_W     = 4;        // width of the word counter
	localparam logic [7:0]  CFG4_RESET     = 8'h00;    // fourth configuration reset value
	localparam int          CFG4_COMP_BIT  = 1;        // comparator enable bit position
	localparam int          CFG1_CHAIN_BIT = 6;        // chain-mode enable bit position
	localparam logic [7:0]  CFG1_RESET     = 8'h00;    // first configuration reset value
	localparam logic [23:0] STATUS_HEAD    = 24'hc00000; // fixed status header nibble
	localparam int          BUF_DEPTH      = 2;        // entries in the sample buffer
endpackage
